// ===== rtl/rci_row_clock_irq.sv
// Row clock output, overflow and end-of-message flags, interrupt pin,
// APB register file and a level interrupt for the local processor.
// Assumes operation and marker inputs come from core logic on I_SYS_CLK;
// the slave select and the sensed pin levels are asynchronous.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rci_row_clock_irq #(
	parameter int unsigned SAMPLE_HZ = rci_pkg::SAMPLE_HZ_NOM,
	parameter int unsigned ROW_HIGH_CYC = rci_pkg::ROW_HIGH_CYC,
	parameter int unsigned ROW_LOW_CYC = rci_pkg::ROW_LOW_CYC,
	parameter int unsigned CUE_HIGH_CYC = rci_pkg::CUE_HIGH_CYC,
	parameter int unsigned CNT_W = 26
) (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [rci_pkg::ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	output logic O_IRQ,
	// Device core
	input wire logic I_OP_RECORD,
	input wire logic I_OP_PLAY,
	input wire logic I_ADDR_AT_LAST,
	input wire logic [7:0] I_ROW_EOM_MARKS,
	input wire logic I_READ_INT_INSTR,
	output logic O_OP_HALT,
	output logic [1:0] O_INT_REPORT,
	output logic O_INT_REPORT_VALID,
	// Serial select pin
	input wire logic I_SS_N,
	// Row boundary clock pin, open drain
	input wire logic I_ROW_BOUNDARY_CLOCK,
	output logic O_ROW_BOUNDARY_CLOCK,
	output logic O_ROW_BOUNDARY_CLOCK_OE_N,
	// Interrupt pin, open drain
	input wire logic I_INT_PIN,
	output logic O_INT_PIN,
	output logic O_INT_PIN_OE_N
);
	// Times scale with samples per row at the selected rate
	localparam longint SCALED_HIGH =
		longint'(ROW_HIGH_CYC) * rci_pkg::SAMPLE_HZ_NOM / SAMPLE_HZ;
	localparam longint SCALED_LOW =
		longint'(ROW_LOW_CYC) * rci_pkg::SAMPLE_HZ_NOM / SAMPLE_HZ;
	localparam longint SCALED_CUE_HIGH =
		longint'(CUE_HIGH_CYC) * rci_pkg::SAMPLE_HZ_NOM / SAMPLE_HZ;
	localparam longint SCALED_CUE_LOW =
		longint'(rci_pkg::CUE_LOW_CYC) * rci_pkg::SAMPLE_HZ_NOM / SAMPLE_HZ;

	// Registers
	rci_pkg::rci_ctrl_t ctrl;
	rci_pkg::rci_irq_t status;
	rci_pkg::rci_irq_t mask;
	rci_pkg::rci_irq_t next_status;
	rci_pkg::rci_flags_t flags;
	rci_pkg::rci_flags_t next_flags;
	rci_pkg::rci_flags_t report_cap;
	rci_pkg::rci_irq_t events;

	// Synchronisers
	logic ss_s1;
	logic ss_s2;
	logic ss_s3;
	logic rbc_s1;
	logic rbc_s2;
	logic int_s1;
	logic int_s2;

	// Edge history of core inputs
	logic rec_q;
	logic last_q;

	// Row timer results
	logic row_level;
	logic row_end;
	logic seg_tick;
	logic [2:0] seg_idx;

	// APB decode
	wire apb_setup = I_PSEL && !I_PENABLE;
	wire apb_access = I_PSEL && I_PENABLE && O_PREADY;
	wire apb_wr = apb_access && I_PWRITE;
	wire sel_ctrl = I_PADDR == rci_pkg::OFS_CTRL;
	wire sel_status = I_PADDR == rci_pkg::OFS_STATUS;
	wire sel_mask = I_PADDR == rci_pkg::OFS_MASK;
	wire sel_state = I_PADDR == rci_pkg::OFS_STATE;
	wire mapped = sel_ctrl || sel_status || sel_mask || sel_state;
	wire status_rd = apb_access && !I_PWRITE && sel_status;

	// Operation state
	wire op_active = I_OP_RECORD || I_OP_PLAY;
	wire rec_start = I_OP_RECORD && !rec_q;
	wire playback = I_OP_PLAY && !I_OP_RECORD;

	// Serial cycle begins when slave select falls
	wire cycle_start = ss_s3 && !ss_s2;

	wire ovf_evt = op_active && I_ADDR_AT_LAST && !last_q;
	wire eom_evt = playback && ctrl.eom_en && seg_tick &&
		I_ROW_EOM_MARKS[seg_idx];

	wire [7:0] state_word;
	wire [31:0] rd_mux;

	assign state_word[rci_pkg::ST_ROW_LEVEL] = row_level;
	assign state_word[rci_pkg::ST_SEG_LSB +: 3] = seg_idx;
	assign state_word[rci_pkg::ST_OVF] = flags.ovf;
	assign state_word[rci_pkg::ST_EOM] = flags.end_of_message_flag;
	assign state_word[rci_pkg::ST_ROW_PIN] = rbc_s2;
	assign state_word[rci_pkg::ST_INT_PIN] = int_s2;

	assign rd_mux = sel_ctrl ? {30'h0, ctrl} :
		sel_status ? {29'h0, status} :
		sel_mask ? {29'h0, mask} :
		sel_state ? {24'h0, state_word} : 32'h0;

	assign events.ovf = ovf_evt;
	assign events.end_of_message_flag = eom_evt;
	assign events.row_end = row_end;

	// Read clears only bits already shown; new events win
	always_comb begin
		next_status = status;
		if (status_rd) begin
			next_status = status & ~rci_pkg::rci_irq_t'(O_PRDATA[2:0]);
		end
		next_status = next_status | events;
	end

	// A serial cycle clears the pin flags; a same-cycle event still sets
	always_comb begin
		next_flags = flags;
		if (cycle_start) begin
			next_flags = '0;
		end
		next_flags.ovf = next_flags.ovf || ovf_evt;
		next_flags.end_of_message_flag = next_flags.end_of_message_flag || eom_evt;
	end

	rci_row_timer #(
		.CNT_W(CNT_W),
		.HIGH_CYC(int'(SCALED_HIGH)),
		.LOW_CYC(int'(SCALED_LOW)),
		.CUE_HIGH_CYC(int'(SCALED_CUE_HIGH)),
		.CUE_LOW_CYC(int'(SCALED_CUE_LOW))
	) u_row_timer (
		.i_clk(I_SYS_CLK),
		.i_reset(I_RESET),
		.i_run(op_active),
		.i_cue(ctrl.cue),
		.i_rec_start(rec_start),
		.o_level(row_level),
		.o_row_end(row_end),
		.o_seg_tick(seg_tick),
		.o_seg_idx(seg_idx)
	);

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ss_s1 <= 1'b1;
			ss_s2 <= 1'b1;
			ss_s3 <= 1'b1;
			rbc_s1 <= 1'b1;
			rbc_s2 <= 1'b1;
			int_s1 <= 1'b1;
			int_s2 <= 1'b1;
		end else begin
			ss_s1 <= I_SS_N;
			ss_s2 <= ss_s1;
			ss_s3 <= ss_s2;
			rbc_s1 <= I_ROW_BOUNDARY_CLOCK;
			rbc_s2 <= rbc_s1;
			int_s1 <= I_INT_PIN;
			int_s2 <= int_s1;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			rec_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			rec_q <= I_OP_RECORD;
			last_q <= I_ADDR_AT_LAST;
		end
	end

	// APB slave: one wait-free access phase
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA <= 32'h0;
		end else begin
			O_PREADY <= apb_setup;
			O_PSLVERR <= apb_setup && !mapped;
			if (apb_setup) begin
				O_PRDATA <= I_PWRITE ? 32'h0 : rd_mux;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ctrl <= rci_pkg::CTRL_RST;
			mask <= rci_pkg::MASK_RST;
		end else begin
			if (apb_wr && sel_ctrl) begin
				ctrl <= rci_pkg::rci_ctrl_t'(I_PWDATA[1:0]);
			end
			if (apb_wr && sel_mask) begin
				mask <= rci_pkg::rci_irq_t'(I_PWDATA[2:0]);
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			status <= '0;
			O_IRQ <= 1'b0;
		end else begin
			status <= next_status;
			O_IRQ <= |(next_status & mask);
		end
	end

	// Pin flags, captured for the host at each cycle start
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			flags <= '0;
			report_cap <= '0;
		end else begin
			flags <= next_flags;
			if (cycle_start) begin
				report_cap <= flags;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_INT_REPORT <= 2'h0;
			O_INT_REPORT_VALID <= 1'b0;
			O_OP_HALT <= 1'b0;
		end else begin
			O_INT_REPORT_VALID <= I_READ_INT_INSTR;
			if (I_READ_INT_INSTR) begin
				O_INT_REPORT <= report_cap;
			end
			O_OP_HALT <= ovf_evt || eom_evt;
		end
	end

	// Open-drain pins: data always low, enable low while pulling
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_ROW_BOUNDARY_CLOCK <= 1'b0;
			O_ROW_BOUNDARY_CLOCK_OE_N <= 1'b1;
			O_INT_PIN <= 1'b0;
			O_INT_PIN_OE_N <= 1'b1;
		end else begin
			O_ROW_BOUNDARY_CLOCK <= 1'b0;
			O_ROW_BOUNDARY_CLOCK_OE_N <= row_level;
			O_INT_PIN <= 1'b0;
			O_INT_PIN_OE_N <= !(next_flags.ovf || next_flags.end_of_message_flag);
		end
	end
endmodule // rci_row_clock_irq
`default_nettype wire

// ===== rtl/rci_pkg.sv
// Shared constants and types of the row clock and interrupt status block.
// Assumes a 40 MHz system clock and an 8 kHz nominal sample rate.
`default_nettype none
package rci_pkg;
	// System clock and nominal sampling
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned SAMPLE_HZ_NOM = 8000;

	// Row clock times, as printed
	localparam int unsigned ROW_HIGH_MS = 175;
	localparam int unsigned ROW_LOW_MS = 25;
	localparam int unsigned CUE_HIGH_CENTI_US = 10937;
	localparam int unsigned CUE_LOW_CENTI_US = 1563;

	// Row clock times in clock cycles (least times round up)
	localparam int unsigned ROW_HIGH_CYC = ROW_HIGH_MS * (CLK_HZ / 1000);
	localparam int unsigned ROW_LOW_CYC = ROW_LOW_MS * (CLK_HZ / 1000);
	localparam int unsigned CUE_HIGH_CYC =
		(CUE_HIGH_CENTI_US * (CLK_HZ / 1_000_000) + 99) / 100;
	localparam int unsigned CUE_LOW_CYC =
		(CUE_LOW_CENTI_US * (CLK_HZ / 1_000_000) + 99) / 100;

	// End-of-message positions per row
	localparam int unsigned EOM_POSITIONS = 8;

	// APB register offsets
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;

	// Field positions of the state register
	localparam int unsigned ST_ROW_LEVEL = 0;
	localparam int unsigned ST_SEG_LSB = 1;
	localparam int unsigned ST_OVF = 4;
	localparam int unsigned ST_EOM = 5;
	localparam int unsigned ST_ROW_PIN = 6;
	localparam int unsigned ST_INT_PIN = 7;

	// Control register: bit 1 eom detect enable, bit 0 cueing mode
	typedef struct packed {
		logic eom_en;
		logic cue;
	} rci_ctrl_t;

	// Sticky event bits, same layout in status and mask
	typedef struct packed {
		logic row_end;
		logic end_of_message_flag;
		logic ovf;
	} rci_irq_t;

	// Interrupt pin flags as reported to the host
	typedef struct packed {
		logic end_of_message_flag;
		logic ovf;
	} rci_flags_t;

	// Reset values
	localparam rci_ctrl_t CTRL_RST = 2'h2;
	localparam rci_irq_t MASK_RST = 3'h0;

	typedef enum logic [1:0] {
		RCI_IDLE,
		RCI_PRELOAD,
		RCI_HIGH,
		RCI_LOW
	} rci_row_state_t;
endpackage
`default_nettype wire

// ===== rtl/rci_row_timer.sv
// Row clock timer: row high and low phases, preload and eight segments.
// Assumes run, cue and record start come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rci_row_timer #(
	parameter int unsigned CNT_W = 24,
	parameter int unsigned HIGH_CYC = 7000000,
	parameter int unsigned LOW_CYC = 1000000,
	parameter int unsigned CUE_HIGH_CYC = 4375,
	parameter int unsigned CUE_LOW_CYC = 626
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Control
	input wire logic i_run,
	input wire logic i_cue,
	input wire logic i_rec_start,
	// Row state
	output logic o_level,
	output logic o_row_end,
	output logic o_seg_tick,
	output logic [2:0] o_seg_idx
);
	localparam logic [CNT_W-1:0] H_LAST = CNT_W'(HIGH_CYC - 1);
	localparam logic [CNT_W-1:0] L_LAST = CNT_W'(LOW_CYC - 1);
	localparam logic [CNT_W-1:0] CH_LAST = CNT_W'(CUE_HIGH_CYC - 1);
	localparam logic [CNT_W-1:0] CL_LAST = CNT_W'(CUE_LOW_CYC - 1);
	localparam logic [CNT_W-1:0] S_LAST =
		CNT_W'((HIGH_CYC + LOW_CYC) / rci_pkg::EOM_POSITIONS - 1);
	localparam logic [CNT_W-1:0] CS_LAST =
		CNT_W'((CUE_HIGH_CYC + CUE_LOW_CYC) / rci_pkg::EOM_POSITIONS - 1);

	rci_pkg::rci_row_state_t state;
	rci_pkg::rci_row_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] seg_cnt;

	wire [CNT_W-1:0] high_last = i_cue ? CH_LAST : H_LAST;
	wire [CNT_W-1:0] low_last = i_cue ? CL_LAST : L_LAST;
	wire [CNT_W-1:0] seg_last = i_cue ? CS_LAST : S_LAST;
	wire cnt_done = cnt == ((state == rci_pkg::RCI_HIGH) ?
		high_last : low_last);
	wire seg_wrap = seg_cnt == seg_last;
	wire row_start = (next_state == rci_pkg::RCI_HIGH) &&
		(state != rci_pkg::RCI_HIGH);
	wire in_row = (state == rci_pkg::RCI_HIGH) ||
		(state == rci_pkg::RCI_LOW);

	always_comb begin
		next_state = state;
		case (state)
			rci_pkg::RCI_IDLE: begin
				if (i_run && i_rec_start) begin
					next_state = rci_pkg::RCI_PRELOAD;
				end else if (i_run) begin
					next_state = rci_pkg::RCI_HIGH;
				end
			end
			rci_pkg::RCI_PRELOAD: begin
				if (cnt_done) begin
					next_state = rci_pkg::RCI_HIGH;
				end
			end
			rci_pkg::RCI_HIGH: begin
				if (cnt_done) begin
					next_state = rci_pkg::RCI_LOW;
				end
			end
			default: begin
				if (cnt_done) begin
					next_state = rci_pkg::RCI_HIGH;
				end
			end
		endcase
		if (!i_run) begin
			next_state = rci_pkg::RCI_IDLE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= rci_pkg::RCI_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= (next_state != state) ? '0 : cnt + 1'b1;
		end
	end

	// Eight segments per row for end-of-message positions
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_run) begin
			seg_cnt <= '0;
			o_seg_idx <= 3'h0;
			o_seg_tick <= 1'b0;
		end else if (row_start) begin
			seg_cnt <= '0;
			o_seg_idx <= 3'h0;
			o_seg_tick <= 1'b1;
		end else if (in_row) begin
			seg_cnt <= seg_wrap ? '0 : seg_cnt + 1'b1;
			o_seg_idx <= o_seg_idx + 3'(seg_wrap);
			o_seg_tick <= seg_wrap && (o_seg_idx != 3'h7);
		end else begin
			o_seg_tick <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_level <= 1'b1;
			o_row_end <= 1'b0;
		end else begin
			o_level <= next_state != rci_pkg::RCI_LOW;
			o_row_end <= (next_state == rci_pkg::RCI_LOW) &&
				(state == rci_pkg::RCI_HIGH);
		end
	end
endmodule // rci_row_timer
`default_nettype wire

// ===== sim/rci_row_clock_irq_asserts.sv
// Port checker of the row clock and interrupt block.
// Assumes a bind to rci_row_clock_irq, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rci_checker #(
	parameter int unsigned ROW_LOW_CYC = 8
) (
	// Clock, reset and bus
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [rci_pkg::ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	// Core and pins
	input wire logic I_OP_RECORD,
	input wire logic I_OP_PLAY,
	input wire logic I_READ_INT_INSTR,
	input wire logic O_OP_HALT,
	input wire logic O_INT_REPORT_VALID,
	input wire logic I_SS_N,
	input wire logic O_ROW_BOUNDARY_CLOCK,
	input wire logic O_ROW_BOUNDARY_CLOCK_OE_N,
	input wire logic O_INT_PIN,
	input wire logic O_INT_PIN_OE_N
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	logic cue;
	int unsigned low_cnt;
	wire logic op_on = I_OP_RECORD || I_OP_PLAY;
	wire logic ctrl_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
		&& I_PADDR == rci_pkg::OFS_CTRL;
	// Cueing mode as last written
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET)
			cue <= 1'b0;
		else if (ctrl_wr)
			cue <= I_PWDATA[0];
	end
	always_ff @(posedge I_SYS_CLK) begin
		if (O_ROW_BOUNDARY_CLOCK_OE_N)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	sequence bus_setup;
		I_PSEL && !I_PENABLE;
	endsequence
	sequence select_start;
		$fell(I_SS_N) ##1 !I_SS_N [*2];
	endsequence
	ready_after_setup_a: assert property (bus_setup |=> O_PREADY)
		else $error("ready missing after setup");
	ready_single_a: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	error_has_ready_a: assert property (O_PSLVERR |-> O_PREADY)
		else $error("error without ready");
	row_drive_low_a: assert property (!O_ROW_BOUNDARY_CLOCK)
		else $error("row pin driven high");
	row_idle_release_a: assert property (
		!op_on [*3] |-> O_ROW_BOUNDARY_CLOCK_OE_N)
		else $error("row pin held while idle");
	row_low_width_a: assert property (
		$rose(O_ROW_BOUNDARY_CLOCK_OE_N) && op_on
		&& !cue |-> low_cnt == ROW_LOW_CYC)
		else $error("row low time wrong");
	int_on_halt_a: assert property (
		O_OP_HALT |-> !O_INT_PIN_OE_N && !O_INT_PIN)
		else $error("interrupt pin not pulled at halt");
	int_hold_a: assert property (
		!O_INT_PIN_OE_N && I_SS_N |=> !O_INT_PIN_OE_N)
		else $error("interrupt released without cycle");
	int_release_a: assert property (
		select_start |-> ##[0:2] O_INT_PIN_OE_N)
		else $error("interrupt not released at cycle");
	report_pulse_a: assert property (
		I_READ_INT_INSTR |=> O_INT_REPORT_VALID ##1 !O_INT_REPORT_VALID)
		else $error("report pulse wrong");
endmodule // rci_checker
bind rci_row_clock_irq rci_checker #(.ROW_LOW_CYC(ROW_LOW_CYC)) u_chk (
	.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.I_OP_RECORD(I_OP_RECORD), .I_OP_PLAY(I_OP_PLAY),
	.I_READ_INT_INSTR(I_READ_INT_INSTR), .O_OP_HALT(O_OP_HALT),
	.O_INT_REPORT_VALID(O_INT_REPORT_VALID), .I_SS_N(I_SS_N),
	.O_ROW_BOUNDARY_CLOCK(O_ROW_BOUNDARY_CLOCK),
	.O_ROW_BOUNDARY_CLOCK_OE_N(O_ROW_BOUNDARY_CLOCK_OE_N),
	.O_INT_PIN(O_INT_PIN), .O_INT_PIN_OE_N(O_INT_PIN_OE_N)
);
`default_nettype wire

// ===== sim/rci_host_model.sv
// Host model: serial cycle start, read instruction and pull-ups.
// Assumes requests from the bench on the system clock.
`timescale 1ns/1ps
`default_nettype none
module rci_host_model (
	// Clock and request
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [3:0] i_gap,
	// Device pins
	input wire logic i_int_oe_n,
	input wire logic i_int_data,
	input wire logic i_row_oe_n,
	input wire logic i_row_data,
	output logic o_ss_n,
	output logic o_rd_int,
	output logic o_busy,
	output logic o_int_wire,
	output logic o_row_wire
);
	// Pull-ups hold released pins high
	assign o_int_wire = i_int_oe_n ? 1'b1 : i_int_data;
	assign o_row_wire = i_row_oe_n ? 1'b1 : i_row_data;
	initial begin
		o_ss_n = 1'b1;
		o_rd_int = 1'b0;
		o_busy = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				o_busy <= 1'b1;
				o_ss_n <= 1'b0;
				repeat (4 + i_gap) @(posedge i_clk);
				o_rd_int <= 1'b1;
				@(posedge i_clk);
				o_rd_int <= 1'b0;
				repeat (2) @(posedge i_clk);
				o_ss_n <= 1'b1;
				o_busy <= 1'b0;
			end
		end
	end
endmodule // rci_host_model
`default_nettype wire

// ===== sim/rci_row_clock_irq_bench.sv
// Self-checking bench of the row clock and interrupt block.
// Assumes shortened row times and the host model's pull-ups.
`timescale 1ns/1ps
`default_nettype none
module rci_row_clock_irq_bench;
	localparam int unsigned HI = 56;
	localparam int unsigned LO = 8;
	localparam int unsigned CH = 60;
	logic clk, rst, psel, pen, pwr, rec, play, last, go, slv;
	logic [7:0] paddr, marks;
	logic [31:0] pwdata, prdata, seen, r;
	logic [63:0] e;
	logic [63:0] expq[$];
	logic pready, pslverr, irq, halt, rep_v, ss_n, rd_int, busy;
	logic row_w, int_w, row_oe, int_oe, row_d, int_d;
	logic [1:0] rep;
	logic [3:0] gap;
	int error_cnt, total_checks, n;
	rci_row_clock_irq #(.ROW_HIGH_CYC(HI), .ROW_LOW_CYC(LO),
		.CUE_HIGH_CYC(CH)) dut (
		.I_SYS_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.O_IRQ(irq), .I_OP_RECORD(rec), .I_OP_PLAY(play),
		.I_ADDR_AT_LAST(last), .I_ROW_EOM_MARKS(marks),
		.I_READ_INT_INSTR(rd_int), .O_OP_HALT(halt), .O_INT_REPORT(rep),
		.O_INT_REPORT_VALID(rep_v), .I_SS_N(ss_n),
		.I_ROW_BOUNDARY_CLOCK(row_w), .O_ROW_BOUNDARY_CLOCK(row_d),
		.O_ROW_BOUNDARY_CLOCK_OE_N(row_oe), .I_INT_PIN(int_w),
		.O_INT_PIN(int_d), .O_INT_PIN_OE_N(int_oe));
	rci_host_model host (.i_clk(clk), .i_go(go), .i_gap(gap),
		.i_int_oe_n(int_oe), .i_int_data(int_d), .i_row_oe_n(row_oe),
		.i_row_data(row_d), .o_ss_n(ss_n), .o_rd_int(rd_int), .o_busy(busy),
		.o_int_wire(int_w), .o_row_wire(row_w));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task tmo;
		error_cnt++;
		final_report();
	endtask
	// Read results and interrupt reports against queued notes
	always @(posedge clk) begin
		if ((psel && pen && pready && !pwr) || rep_v) begin
			seen = rep_v ? {30'h0, rep} : prdata;
			if (expq.size() == 0)
				check(32'h0, 32'h1);
			else begin
				e = expq.pop_front();
				check(seen & e[63:32], e[31:0]);
			end
		end
	end
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		k = 0;
		while (pready !== 1'b1) begin
			k++;
			if (k > 20)
				tmo();
			@(posedge clk);
		end
		slv = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// One idle edge so a following call never reassigns psel at once
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] care, input logic [31:0] x);
		expq.push_back({care, x});
		apb(1'b0, a, 32'h0);
	endtask
	task meas(input logic lvl);
		n = 0;
		while (row_oe === lvl) begin
			@(posedge clk);
			n++;
			if (n > 9000)
				tmo();
		end
	endtask
	task wait_int;
		n = 0;
		while (int_w !== 1'b0) begin
			@(posedge clk);
			n++;
			if (n > 200)
				tmo();
		end
	endtask
	task host_cycle(input logic [1:0] x);
		expq.push_back({32'h3, 30'h0, x});
		gap <= 4'($urandom_range(0, 7));
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		n = 0;
		while (busy) begin
			@(posedge clk);
			n++;
			if (n > 40)
				tmo();
		end
		@(posedge clk);
	endtask
	initial begin
		{psel, pen, pwr, rec, play, last, go} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		marks = 8'h00;
		gap = 4'h0;
		rst = 1'b1;
		error_cnt = 0;
		total_checks = 0;
		void'($urandom(26054));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(rci_pkg::OFS_CTRL, '1, 32'h2);
		rd(rci_pkg::OFS_MASK, '1, 32'h0);
		rd(rci_pkg::OFS_STATUS, '1, 32'h0);
		rd(8'h10, '1, 32'h0);
		check(32'(slv), 32'h1);
		r = 32'($urandom_range(0, 7));
		apb(1'b1, rci_pkg::OFS_MASK, r);
		rd(rci_pkg::OFS_MASK, '1, r);
		apb(1'b1, rci_pkg::OFS_MASK, 32'h1);
		// Normal rows, then cueing rows
		play <= 1'b1;
		meas(1'b1);
		meas(1'b0);
		check(32'(n), 32'(LO));
		meas(1'b1);
		check(32'(n), 32'(HI));
		play <= 1'b0;
		repeat (4) @(posedge clk);
		check(32'(row_w), 32'h1);
		apb(1'b1, rci_pkg::OFS_CTRL, 32'h3);
		play <= 1'b1;
		meas(1'b1);
		meas(1'b0);
		check(32'(n), 32'(rci_pkg::CUE_LOW_CYC));
		meas(1'b1);
		check(32'(n), 32'(CH));
		play <= 1'b0;
		apb(1'b1, rci_pkg::OFS_CTRL, 32'h2);
		repeat (4) @(posedge clk);
		// Record with markers, then end of memory
		marks <= 8'hFF;
		rec <= 1'b1;
		@(posedge clk);
		meas(1'b1);
		check(32'(n + 1 >= LO + HI && n <= LO + HI + 2), 32'h1);
		meas(1'b0);
		check({30'h0, int_w, irq}, 32'h2);
		last <= 1'b1;
		wait_int();
		check(32'(irq), 32'h1);
		rec <= 1'b0;
		last <= 1'b0;
		host_cycle(2'h1);
		check(32'(int_w), 32'h1);
		rd(rci_pkg::OFS_STATUS, 32'h3, 32'h1);
		check(32'(irq), 32'h0);
		rd(rci_pkg::OFS_STATUS, 32'h1, 32'h0);
		// Marker at each of the eight row positions
		for (int p = 0; p < 8; p++) begin
			marks <= 8'h01 << p;
			play <= 1'b1;
			wait_int();
			play <= 1'b0;
			check(32'(irq), 32'h0);
			host_cycle(2'h2);
			check(32'(int_w), 32'h1);
		end
		final_report();
	end
endmodule // rci_row_clock_irq_bench
`default_nettype wire
